// ===== mdsw_defs.svh
`ifndef MDSW_DEFS_SVH
`define MDSW_DEFS_SVH

// Frame geometry
`define MDSW_FRAME_BITS    19
`define MDSW_DAC_BITS      6
// Field positions within a word 0 frame
`define MDSW_SEL_POS       0
`define MDSW_DAC1_LSB      1
`define MDSW_DAC2_LSB      7
`define MDSW_DIR1_POS      13
`define MDSW_DIR2_POS      14
`define MDSW_DECAY1_POS    15
`define MDSW_DECAY2_POS    16
`define MDSW_REFSEL_POS    17
`define MDSW_RANGE_POS     18
// Reset value and word 0 selector value
`define MDSW_WORD_RESET    19'h00000
`define MDSW_SEL_WORD0     1'h0

`endif

// ===== mdsw_pkg.sv
package mdsw_pkg;

    typedef enum logic {
        MDSW_DECAY_MIXED,
        MDSW_DECAY_SLOW
    } mdsw_decay_t;

    // Decoded state of one full bridge
    typedef struct packed {
        logic [5:0]  current_code;
        logic        direction;
        mdsw_decay_t decay;
        logic        enable;
        logic        out_a;
        logic        out_b;
    } mdsw_bridge_t;

    // Shared reference settings
    typedef struct packed {
        logic ref_external;
        logic range_quarter;
    } mdsw_ref_t;

    // Link-clock domain state
    typedef struct packed {
        logic [18:0] shift;
        logic [18:0] frame;
        logic        frame_tgl;
    } mdsw_link_t;

    // Core domain state
    typedef struct packed {
        logic [18:0] word0;
        logic [18:0] word1;
        logic [2:0]  tgl_sync;
        logic [1:0]  sleep_sync;
        logic [1:0]  lock_sync;
    } mdsw_core_t;

endpackage

// ===== mdsw_serial_word0.sv
`timescale 1ns/1ps
`include "mdsw_defs.svh"

module mdsw_serial_word0 #(
    parameter int FRAME_BITS = `MDSW_FRAME_BITS
) (
    // Core clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // Serial link from host
    input  wire logic                 ser_clk,
    input  wire logic                 ser_data,
    input  wire logic                 ser_strobe,
    // Power control pins
    input  wire logic                 sleep_n,
    input  wire logic                 supply_lockout,
    // Decoded word 0
    output mdsw_pkg::mdsw_bridge_t    bridge_one,
    output mdsw_pkg::mdsw_bridge_t    bridge_two,
    output mdsw_pkg::mdsw_ref_t       ref_cfg,
    // Bridge output pins
    output logic                      bridge_one_out_a,
    output logic                      bridge_one_out_b,
    output logic                      bridge_two_out_a,
    output logic                      bridge_two_out_b,
    // Raw stored words
    output logic [FRAME_BITS-1:0]     word0_q,
    output logic [FRAME_BITS-1:0]     word1_q
);

    // The field decode is fixed to the 19-bit frame layout
    if (FRAME_BITS != `MDSW_FRAME_BITS) begin : g_bad_frame
        $error("FRAME_BITS must be 19");
    end

    mdsw_pkg::mdsw_link_t link_ff;
    mdsw_pkg::mdsw_link_t nxt_link;
    mdsw_pkg::mdsw_core_t core_ff;
    mdsw_pkg::mdsw_core_t nxt_core;
    logic                 port_clear_n;
    logic                 link_rst_n;
    logic [1:0]           link_rst_sync_ff;

    // Reset, sleep or lockout from pins, applied unsynchronised as the link-reset clear
    assign port_clear_n = arst_n & sleep_n & ~supply_lockout;

    // Async assert, link-clock release; the link clock may idle, so the
    // clear must act without any edge of it
    always_ff @(posedge ser_clk or negedge port_clear_n) begin
        if (!port_clear_n) begin
            link_rst_sync_ff <= 2'h0;
        end else begin
            link_rst_sync_ff <= {link_rst_sync_ff[0], 1'b1};
        end
    end
    assign link_rst_n = link_rst_sync_ff[1];

    // Link side: shift on each serial clock without strobe, latch frame on strobe
    always_comb begin
        nxt_link = link_ff;
        if (ser_strobe) begin
            nxt_link.frame     = link_ff.shift;
            nxt_link.frame_tgl = ~link_ff.frame_tgl;
        end else begin
            // Bit 18 enters first and ends at the top after 19 clocks
            nxt_link.shift = {link_ff.shift[FRAME_BITS-2:0], ser_data};
        end
    end

    // Strobe is sampled on the link clock; host gives a clock edge with it high
    always_ff @(posedge ser_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_ff <= '0;
        end else begin
            link_ff <= nxt_link;
        end
    end

    // Core side: toggle crossing; frame is stable while toggle settles
    always_comb begin
        nxt_core            = core_ff;
        nxt_core.sleep_sync = {core_ff.sleep_sync[0], sleep_n};
        nxt_core.lock_sync  = {core_ff.lock_sync[0], supply_lockout};
        nxt_core.tgl_sync   = {core_ff.tgl_sync[1:0], link_ff.frame_tgl};
        if (core_ff.tgl_sync[2] != core_ff.tgl_sync[1]) begin
            if (link_ff.frame[`MDSW_SEL_POS] == `MDSW_SEL_WORD0) begin
                nxt_core.word0 = link_ff.frame;
            end else begin
                nxt_core.word1 = link_ff.frame;
            end
        end
        if (!core_ff.sleep_sync[1] || core_ff.lock_sync[1]) begin
            nxt_core.word0 = `MDSW_WORD_RESET;
            nxt_core.word1 = `MDSW_WORD_RESET;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_ff <= '0;
        end else begin
            core_ff <= nxt_core;
        end
    end

    // Decode of word 0
    logic powered;
    assign powered = core_ff.sleep_sync[1] & ~core_ff.lock_sync[1];

    // Both bridges use the same decoder module so their behaviour cannot drift apart
    mdsw_bridge_decode #(
        .CODE_BITS (`MDSW_DAC_BITS)
    ) u_bridge_one (
        .code      (core_ff.word0[`MDSW_DAC1_LSB +: `MDSW_DAC_BITS]),
        .dir       (core_ff.word0[`MDSW_DIR1_POS]),
        .slow      (core_ff.word0[`MDSW_DECAY1_POS]),
        .powered   (powered),
        .bridge    (bridge_one)
    );

    mdsw_bridge_decode #(
        .CODE_BITS (`MDSW_DAC_BITS)
    ) u_bridge_two (
        .code      (core_ff.word0[`MDSW_DAC2_LSB +: `MDSW_DAC_BITS]),
        .dir       (core_ff.word0[`MDSW_DIR2_POS]),
        .slow      (core_ff.word0[`MDSW_DECAY2_POS]),
        .powered   (powered),
        .bridge    (bridge_two)
    );

    always_comb begin
        ref_cfg.ref_external  = core_ff.word0[`MDSW_REFSEL_POS];
        ref_cfg.range_quarter = core_ff.word0[`MDSW_RANGE_POS];
    end

    assign bridge_one_out_a = bridge_one.out_a;
    assign bridge_one_out_b = bridge_one.out_b;
    assign bridge_two_out_a = bridge_two.out_a;
    assign bridge_two_out_b = bridge_two.out_b;
    assign word0_q          = core_ff.word0;
    assign word1_q          = core_ff.word1;

endmodule // mdsw_serial_word0

module mdsw_bridge_decode #(
    parameter int CODE_BITS = `MDSW_DAC_BITS
) (
    // Word 0 fields of one bridge
    input  wire logic [CODE_BITS-1:0] code,
    input  wire logic                 dir,
    input  wire logic                 slow,
    // Power state
    input  wire logic                 powered,
    // Decoded bridge
    output mdsw_pkg::mdsw_bridge_t    bridge
);

    // The bridge struct carries a fixed six-bit code
    if (CODE_BITS != `MDSW_DAC_BITS) begin : g_bad_code
        $error("CODE_BITS must match the bridge current code width");
    end

    logic enable;

    // Zero code turns both drivers off, so neither side can conduct
    assign enable = powered && (code != '0);

    always_comb begin
        bridge.current_code = code;
        bridge.direction    = dir;
        bridge.decay        = slow ? mdsw_pkg::MDSW_DECAY_SLOW : mdsw_pkg::MDSW_DECAY_MIXED;
        bridge.enable       = enable;
        bridge.out_a        = enable & dir;
        bridge.out_b        = enable & ~dir;
    end

endmodule // mdsw_bridge_decode

// ===== mdsw_serial_word0_properties.sv
`timescale 1ns/1ps
module mdsw_serial_word0_properties #(
    parameter int FRAME_BITS = 19
) (
    // Clock and controls
    input logic                   clk,
    input logic                   arst_n,
    input logic                   sleep_n,
    input logic                   supply_lockout,
    // Decoded word 0
    input mdsw_pkg::mdsw_bridge_t bridge_one,
    input mdsw_pkg::mdsw_bridge_t bridge_two,
    input mdsw_pkg::mdsw_ref_t    ref_cfg,
    input logic                   bridge_one_out_a,
    input logic                   bridge_one_out_b,
    input logic                   bridge_two_out_a,
    input logic                   bridge_two_out_b,
    // Stored words
    input logic [FRAME_BITS-1:0]  word0_q,
    input logic [FRAME_BITS-1:0]  word1_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_dac_one: assert property (bridge_one.current_code == word0_q[6:1])
        else $error("bridge one code differs from word");
    a_dac_two: assert property (bridge_two.current_code == word0_q[12:7])
        else $error("bridge two code differs from word");
    a_zero_off: assert property (word0_q[12:1] == 12'h000 |->
        !(bridge_one_out_a | bridge_one_out_b | bridge_two_out_a | bridge_two_out_b))
        else $error("zero code left drivers on");
    a_dir_one: assert property (bridge_one.enable |->
        {bridge_one_out_a, bridge_one_out_b} == {word0_q[13], !word0_q[13]})
        else $error("bridge one pins disagree with direction");
    a_dir_two: assert property (bridge_two.enable |->
        {bridge_two_out_a, bridge_two_out_b} == {word0_q[14], !word0_q[14]})
        else $error("bridge two pins disagree with direction");
    a_bridge_on: assert property ((sleep_n && !supply_lockout) [*4] ##0
        word0_q[6:1] != 6'h00 |-> bridge_one.enable)
        else $error("nonzero code left bridge one off");
    a_decay_sel: assert property ({bridge_one.decay, bridge_two.decay} ==
        {word0_q[15], word0_q[16]})
        else $error("decay mode differs from word");
    a_ref_range: assert property (ref_cfg == {word0_q[17], word0_q[18]})
        else $error("reference settings differ from word");
    a_sleep_clear: assert property (!sleep_n [*5] |-> (word0_q | word1_q) == '0)
        else $error("words not cleared in sleep");
    a_lock_clear: assert property (supply_lockout [*5] |-> (word0_q | word1_q) == '0)
        else $error("words not cleared in lockout");
    c_bridge_on: cover property (bridge_one.enable && bridge_one_out_a);
    c_word1: cover property (word1_q != '0);
    c_sleep: cover property (!sleep_n);
endmodule // mdsw_serial_word0_properties

bind mdsw_serial_word0 mdsw_serial_word0_properties #(.FRAME_BITS(FRAME_BITS)) u_props (
    .clk(clk), .arst_n(arst_n), .sleep_n(sleep_n), .supply_lockout(supply_lockout),
    .bridge_one(bridge_one), .bridge_two(bridge_two), .ref_cfg(ref_cfg),
    .bridge_one_out_a(bridge_one_out_a), .bridge_one_out_b(bridge_one_out_b),
    .bridge_two_out_a(bridge_two_out_a), .bridge_two_out_b(bridge_two_out_b),
    .word0_q(word0_q), .word1_q(word1_q));

// ===== mdsw_host_model.sv
`timescale 1ns/1ps
module mdsw_host_model (
    // Serial lines to the device
    output logic ser_clk,
    output logic ser_data,
    output logic ser_strobe
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_strobe = 1'b0;
    end
    // Two lead edges wake the link; only the last 19 bits count
    task automatic send(input logic [18:0] w);
        for (int i = 20; i >= 0; i--) begin
            ser_data = (i > 18) ? ~w[18] : w[i];
            #7.5 ser_clk = 1'b1;
            #7.5 ser_clk = 1'b0;
        end
        ser_data = ~w[0];
        ser_strobe = 1'b1;
        #7.5 ser_clk = 1'b1;
        #7.5 ser_clk = 1'b0;
        ser_strobe = 1'b0;
    endtask
endmodule // mdsw_host_model

// ===== mdsw_serial_word0_tb_top.sv
`timescale 1ns/1ps
module mdsw_serial_word0_tb_top;
    logic                   clk = 1'b0;
    logic                   arst_n = 1'b0;
    logic                   sleep_n = 1'b1;
    logic                   supply_lockout = 1'b0;
    logic                   sc, sd, ss, o1a, o1b, o2a, o2b;
    mdsw_pkg::mdsw_bridge_t b1, b2;
    mdsw_pkg::mdsw_ref_t    rc;
    logic [18:0]            w0, w1;
    logic [18:0]            tbl [4] = '{19'h7FFFE, 19'h0007E, 19'h01F80, 19'h5A042};
    int                     miscompares = 0;
    int                     compares = 0;
    always #12.5 clk = ~clk;
    mdsw_host_model hm (.ser_clk(sc), .ser_data(sd), .ser_strobe(ss));
    mdsw_serial_word0 dut (.clk(clk), .arst_n(arst_n), .ser_clk(sc), .ser_data(sd),
        .ser_strobe(ss), .sleep_n(sleep_n), .supply_lockout(supply_lockout),
        .bridge_one(b1), .bridge_two(b2), .ref_cfg(rc), .bridge_one_out_a(o1a),
        .bridge_one_out_b(o1b), .bridge_two_out_a(o2a), .bridge_two_out_b(o2b),
        .word0_q(w0), .word1_q(w1));
    function automatic logic [3:0] pins(input logic [18:0] w);
        logic e1;
        logic e2;
        e1 = |w[6:1];
        e2 = |w[12:7];
        return {e1 & w[13], e1 & ~w[13], e2 & w[14], e2 & ~w[14]};
    endfunction
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Answer lands within 4 core edges of the strobe
    task automatic wr(input logic [18:0] w);
        hm.send(w);
        repeat (6) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000 miscompares++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 arst_n = 1'b1;
        foreach (tbl[i]) begin
            wr(tbl[i]);
            chk(w0, tbl[i]);
            chk(19'({rc, b1.decay, b2.decay, b2.current_code, b1.current_code}),
                19'({tbl[i][17], tbl[i][18], tbl[i][15], tbl[i][16], tbl[i][12:1]}));
            chk(19'({o1a, o1b, o2a, o2b}), 19'(pins(tbl[i])));
            chk(19'({b1.enable, b1.direction, b2.enable, b2.direction}),
                19'({|tbl[i][6:1], tbl[i][13], |tbl[i][12:7], tbl[i][14]}));
        end
        wr(19'h12345);
        chk(w0, tbl[3]);
        chk(w1, 19'h12345);
        @(posedge clk) #1 sleep_n = 1'b0;
        repeat (6) @(posedge clk);
        chk(w0 | w1, 19'h00000);
        chk(19'({o1a, o1b, o2a, o2b}), 19'h00000);
        @(posedge clk) #1 sleep_n = 1'b1;
        wr(tbl[0]);
        chk(w0, tbl[0]);
        @(posedge clk) #1 supply_lockout = 1'b1;
        repeat (6) @(posedge clk);
        chk(w0 | w1, 19'h00000);
        chk(19'({o1a, o1b, o2a, o2b}), 19'h00000);
        @(posedge clk) #1 supply_lockout = 1'b0;
        wr(tbl[3]);
        chk(w0, tbl[3]);
        @(posedge clk) #1 arst_n = 1'b0;
        @(posedge clk) #1 arst_n = 1'b1;
        chk(w0 | w1, 19'h00000);
        wr(tbl[1]);
        chk(w0, tbl[1]);
        print_verdict();
    end
endmodule // mdsw_serial_word0_tb_top
